// ### rtl/tia_tx_input_align.sv
// =====================================================================
// tia_tx_input_align: transmit input register, phase-align buffer,
// error character insertion and register access for one channel
// assumes the character, clock and latch pins are asynchronous to mclk and are synchronised here;
// host and reference clocks are far slower than mclk
// the reference clock alone paces characters; the host clock only captures
// a clock select change needs a reinit before the buffer is trusted
`timescale 1ns/1ps
module tia_tx_input_align
  import tia_pkg::*;
#(
  parameter int DEPTH = tia_pkg::BUF_DEPTH
) (
  input  wire logic                    mclk,                // system clock
  input  wire logic                    rst_n,               // sync reset
  // host character pins
  input  wire logic [tia_pkg::CHAR_W-1:0] tx_parallel_char, // character
  input  wire logic                    host_tx_clock,       // host clock
  input  wire logic                    reference_clock_in,  // ref clock
  // configuration latch pins
  input  wire logic                    config_write_strobe, // latch load
  input  wire logic [tia_pkg::CFG_ADDR_W-1:0] config_addr,  // latch addr
  input  wire logic [tia_pkg::CFG_DATA_W-1:0] config_data,  // latch data
  // apb slave
  input  wire logic                    psel,                // select
  input  wire logic                    penable,             // access
  input  wire logic                    pwrite,              // direction
  input  wire logic [tia_pkg::APB_AW-1:0] paddr,            // address
  input  wire logic [31:0]             pwdata,              // write data
  output logic      [31:0]             prdata,              // read data
  output logic                         pready,              // answer
  output logic                         pslverr,             // unmapped
  // line side
  output logic      [tia_pkg::CHAR_W-1:0] tx_line_char,     // sent char
  output logic                         tx_char_valid,       // char strobe
  output logic                         char_rate_clock_out, // char clock
  output logic      [4:0]              tx_bit_multiplier,   // 10 or 20
  output logic                         tx_phase_error,      // error pin
  output logic                         irq                  // interrupt
);
  import tia_pkg::*;

  // pointer width and width of the synchronised pin bus
  localparam int AW = $clog2(DEPTH);
  localparam int SW = CHAR_W + 2 + 1 + CFG_ADDR_W + CFG_DATA_W;

  // ===================================================================
  // pin synchronisers
  // ===================================================================
  // synchroniser stages and edge history
  logic [SW-1:0] pin_meta;
  logic [SW-1:0] pin_sync;
  logic          host_clk_d;
  logic          ref_clk_d;
  logic          strobe_d;

  // two flops on every character, clock and latch pin, second stage feeds all logic
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {tx_parallel_char, host_tx_clock, reference_clock_in,
                   config_write_strobe, config_addr, config_data};
      pin_sync <= pin_meta;
    end
  end

  // unpacked pins; the character word must stay still around its capture edge
  wire [CHAR_W-1:0]     s_char   = pin_sync[SW-1 -: CHAR_W];
  wire                  s_hclk   = pin_sync[SW-1-CHAR_W];
  wire                  s_rclk   = pin_sync[SW-2-CHAR_W];
  wire                  s_strobe = pin_sync[CFG_ADDR_W+CFG_DATA_W];
  wire [CFG_ADDR_W-1:0] s_addr   = pin_sync[CFG_DATA_W +: CFG_ADDR_W];
  wire [CFG_DATA_W-1:0] s_data   = pin_sync[CFG_DATA_W-1:0];

  // edge history of synchronised levels
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      host_clk_d <= 1'b0;
      ref_clk_d  <= 1'b0;
      strobe_d   <= 1'b0;
    end else begin
      host_clk_d <= s_hclk;
      ref_clk_d  <= s_rclk;
      strobe_d   <= s_strobe;
    end
  end

  // ===================================================================
  // configuration latches
  // ===================================================================
  // latched control bits
  logic cksel;
  logic rate;
  logic reinit_latch;

  // latch load on rising strobe at our address
  wire pin_wr   = s_strobe && !strobe_d && (s_addr == CFG_ADDR_TXCTL);
  // apb write taken at the edge where pready is seen high
  wire apb_acc  = psel && penable && pready;
  wire apb_wr   = apb_acc && pwrite;
  wire wr_ctrl  = apb_wr && (paddr == REG_CTRL);
  wire wr_iclr  = apb_wr && (paddr == REG_INT_CLR);
  wire wr_ien   = apb_wr && (paddr == REG_INT_EN);

  // apb wins when both paths write in one cycle
  wire [CFG_DATA_W-1:0] cfg_wdata = wr_ctrl ? pwdata[CFG_DATA_W-1:0]
                                            : s_data;
  wire cfg_wr   = wr_ctrl || pin_wr;
  // each write of 0 to the reinit bit recentres the buffer
  wire reinit   = cfg_wr && !cfg_wdata[CTL_REINIT];

  // latches load from whichever path wrote
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cksel        <= CKSEL_RST;
      rate         <= RATE_RST;
      reinit_latch <= REINIT_RST;
    end else if (cfg_wr) begin
      cksel        <= cfg_wdata[CTL_CKSEL];
      rate         <= cfg_wdata[CTL_RATE];
      reinit_latch <= cfg_wdata[CTL_REINIT];
    end
  end

  // ===================================================================
  // character clock and capture strobes
  // ===================================================================
  // edges of the synchronised clock pins
  wire ref_rise  = s_rclk && !ref_clk_d;
  wire ref_fall  = !s_rclk && ref_clk_d;
  wire host_rise = s_hclk && !host_clk_d;

  // half-rate reference gives two characters per reference period
  wire char_tick = rate ? (ref_rise || ref_fall) : ref_rise;
  // input register clock source
  wire cap_tick  = cksel ? char_tick : host_rise;

  logic [CHAR_W-1:0] in_reg;

  // input register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      in_reg <= '0;
    end else if (cap_tick) begin
      in_reg <= s_char;
    end
  end

  logic cap_pulse;

  // write strobe one cycle after capture so in_reg is settled
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cap_pulse <= 1'b0;
    end else begin
      cap_pulse <= cap_tick && !cksel;
    end
  end

  // ===================================================================
  // phase-align buffer
  // ===================================================================
  // clock select picks the buffered or the bypass path
  wire              use_buf = !cksel;
  wire [CHAR_W-1:0] buf_data;
  wire              buf_err;
  wire [AW:0]       buf_level;
  // buffer is read on every character tick while it is in the path
  wire              buf_rd = char_tick && use_buf;

  tia_phase_buf #(
    .W     (CHAR_W),
    .DEPTH (DEPTH)
  ) u_buf (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .reinit  (reinit),
    .wr_en   (cap_pulse),
    .wr_data (in_reg),
    .rd_en   (buf_rd),
    .rd_data (buf_data),
    .err     (buf_err),
    .level   (buf_level)
  );

  // ===================================================================
  // channel state
  // ===================================================================
  // channel state and its next value
  tia_state_t state;
  tia_state_t next_state;

  // next state: a fault is left only through a reinit
  always_comb begin
    next_state = state;
    case (state)
      TIA_BYPASS: begin
        // buffer joins the path on clock select 0
        if (use_buf) next_state = TIA_ALIGN;
      end
      TIA_ALIGN: begin
        // an over or underrun holds until a reinit
        if (!use_buf) next_state = TIA_BYPASS;
        else if (buf_err && !reinit) next_state = TIA_FAULT;
      end
      TIA_FAULT: begin
        // only a reinit leaves the fault
        if (reinit) next_state = use_buf ? TIA_ALIGN : TIA_BYPASS;
      end
      default: next_state = TIA_BYPASS;
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= TIA_BYPASS;
    end else begin
      state <= next_state;
    end
  end

  // fault view for the line side and status
  wire in_fault = (state == TIA_FAULT);

  // ===================================================================
  // line side outputs
  // ===================================================================
  // buffered path, bypass path, or error character
  wire [CHAR_W-1:0] path_char = use_buf ? buf_data : in_reg;
  wire [CHAR_W-1:0] next_line = in_fault ? ERR_CHAR : path_char;

  // line character and error move only on character ticks
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_line_char   <= '0;
      tx_char_valid  <= 1'b0;
      tx_phase_error <= 1'b0;
    end else begin
      tx_char_valid <= char_tick;
      if (char_tick) begin
        tx_line_char   <= next_line;
        tx_phase_error <= in_fault;
      end
    end
  end

  // bit clock multiplier follows the rate latch
  wire [4:0]        next_mult = rate ? MULT_HALF : MULT_FULL;

  // character clock out: high for one mclk per character
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      char_rate_clock_out <= 1'b0;
      tx_bit_multiplier   <= MULT_FULL;
    end else begin
      char_rate_clock_out <= char_tick;
      tx_bit_multiplier   <= next_mult;
    end
  end

  // ===================================================================
  // interrupts
  // ===================================================================
  // sticky status bits and their enables
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_en;

  // events: fault entered, buffer reinitialised
  wire             enter_fault = (next_state == TIA_FAULT) && !in_fault;
  wire [INT_W-1:0] int_set;
  assign int_set[INT_ERR]  = enter_fault;
  assign int_set[INT_INIT] = reinit;
  wire [INT_W-1:0] int_clr = wr_iclr ? pwdata[INT_W-1:0] : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      int_stat <= '0;
      int_en   <= '0;
      irq      <= 1'b0;
    end else begin
      int_stat <= (int_stat & ~int_clr) | int_set;
      if (wr_ien) int_en <= pwdata[INT_W-1:0];
      irq      <= |(int_stat & int_en);
    end
  end

  // ===================================================================
  // apb slave
  // ===================================================================
  // address decode
  wire hit_ctrl = (paddr == REG_CTRL);
  wire hit_stat = (paddr == REG_STATUS);
  wire hit_ist  = (paddr == REG_INT_STAT);
  wire hit_iclr = (paddr == REG_INT_CLR);
  wire hit_ien  = (paddr == REG_INT_EN);
  wire mapped   = hit_ctrl || hit_stat || hit_ist || hit_iclr || hit_ien;

  // read views of each register
  wire [31:0] rd_ctrl = {29'h0, reinit_latch, rate, cksel};
  wire [31:0] rd_stat = {{(32-STAT_LVL_LSB-AW-1){1'b0}}, buf_level,
                         {(STAT_LVL_LSB-2){1'b0}}, in_fault, tx_phase_error};
  wire [31:0] rd_ist  = {{(32-INT_W){1'b0}}, int_stat};
  wire [31:0] rd_ien  = {{(32-INT_W){1'b0}}, int_en};

  // clear register reads as zero
  wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                        hit_stat ? rd_stat :
                        hit_ist  ? rd_ist  :
                        hit_ien  ? rd_ien  : 32'h0;

  // first access cycle of a transfer, answered at the next edge
  wire apb_first = psel && penable && !pready;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= apb_first;
      pslverr <= apb_first && !mapped;
      prdata  <= (apb_first && !pwrite) ? rd_mux : 32'h0;
    end
  end

endmodule

// ### rtl/tia_pkg.sv
// =====================================================================
// tia_pkg: shared constants for the transmit input phase-align block
// assumes a single 10 MHz clock domain and an APB register bus
package tia_pkg;

  // character path
  localparam int          CHAR_W     = 10;
  localparam logic [9:0]  ERR_CHAR   = 10'h278;  // 1001111000
  localparam int          BUF_DEPTH  = 4;
  localparam logic [4:0]  MULT_FULL  = 5'h0a;    // bit clock = ref x10
  localparam logic [4:0]  MULT_HALF  = 5'h14;    // bit clock = ref x20

  // configuration latch pins
  localparam int          CFG_DATA_W = 7;
  localparam int          CFG_ADDR_W = 4;
  localparam logic [3:0]  CFG_ADDR_TXCTL = 4'h0;

  // control field positions and values after reset
  localparam int          CTL_CKSEL  = 0;
  localparam int          CTL_RATE   = 1;
  localparam int          CTL_REINIT = 2;
  localparam logic        CKSEL_RST  = 1'b0;
  localparam logic        RATE_RST   = 1'b0;
  localparam logic        REINIT_RST = 1'b1;

  // apb map
  localparam int          APB_AW       = 8;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_INT_STAT = 8'h08;
  localparam logic [7:0]  REG_INT_CLR  = 8'h0c;
  localparam logic [7:0]  REG_INT_EN   = 8'h10;
  localparam int          STAT_LVL_LSB = 4;

  // interrupt bits
  localparam int          INT_W    = 2;
  localparam int          INT_ERR  = 0;
  localparam int          INT_INIT = 1;

  // channel state, one-hot
  typedef enum logic [2:0] {
    TIA_BYPASS = 3'b001,
    TIA_ALIGN  = 3'b010,
    TIA_FAULT  = 3'b100
  } tia_state_t;

endpackage

// ### rtl/tia_phase_buf.sv
// =====================================================================
// tia_phase_buf: small phase-align buffer between capture and character
// assumes write and read strobes are single mclk pulses
`timescale 1ns/1ps
module tia_phase_buf #(
  parameter int W     = 10,
  parameter int DEPTH = 4,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          mclk,     // system clock
  input  wire logic          rst_n,    // sync reset, low
  input  wire logic          reinit,   // centre pointers, clear error
  input  wire logic          wr_en,    // capture strobe
  input  wire logic [W-1:0]  wr_data,  // captured character
  input  wire logic          rd_en,    // character clock tick
  output logic      [W-1:0]  rd_data,  // oldest character
  output logic               err,      // sticky overrun/underrun
  output logic      [AW:0]   level     // characters held
);
  localparam logic [AW:0] HALF = (AW+1)'(DEPTH/2);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;

  // capacity checks, the buffer absorbs half its depth in characters either way
  wire do_wr     = wr_en && !err;
  wire do_rd     = rd_en && !err;
  wire overrun   = do_wr && !do_rd && (level == FULL);
  wire underrun  = do_rd && !do_wr && (level == '0);

  assign rd_data = mem[rd_ptr];

  // storage
  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  // pointers, fill level and sticky error
  always_ff @(posedge mclk) begin
    if (!rst_n || reinit) begin
      wr_ptr <= AW'(DEPTH/2);
      rd_ptr <= '0;
      level  <= HALF;
      err    <= 1'b0;
    end else if (overrun || underrun) begin
      err    <= 1'b1;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
      if (do_wr && !do_rd) level <= level + 1'b1;
      else if (do_rd && !do_wr) level <= level - 1'b1;
    end
  end
endmodule

// ### test/tia_tx_input_align_properties.sv
// ==================================================================
// checker for the transmit input phase-align block
// assumes a single mclk domain and the top module's ports only
`timescale 1ns/1ps
module tia_tx_input_align_checker
  import tia_pkg::*;
#(
  parameter int DEPTH = tia_pkg::BUF_DEPTH
) (
  input wire logic                        mclk,                // clock
  input wire logic                        rst_n,               // reset
  input wire logic                        psel,                // select
  input wire logic                        penable,             // access
  input wire logic [31:0]                 prdata,              // rdata
  input wire logic                        pready,              // answer
  input wire logic                        pslverr,             // error
  input wire logic [tia_pkg::CHAR_W-1:0]  tx_line_char,        // char
  input wire logic                        tx_char_valid,       // strobe
  input wire logic                        char_rate_clock_out, // tick
  input wire logic [4:0]                  tx_bit_multiplier,   // mult
  input wire logic                        tx_phase_error       // error
);
  logic [1:0] err_ticks;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ==================================================================
  // sequences
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_near_tick;
    char_rate_clock_out || $past(char_rate_clock_out);
  endsequence

  // character ticks seen while the error stands
  always_ff @(posedge mclk) begin
    if (!rst_n || !tx_phase_error) begin
      err_ticks <= 2'd0;
    end else if (char_rate_clock_out && err_ticks != 2'd3) begin
      err_ticks <= err_ticks + 2'd1;
    end
  end

  // ==================================================================
  // properties
  a_ready_after_setup: assert property (s_setup |-> ##2 pready)
    else $error("answer not two cycles after setup");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  a_slverr_with_ready: assert property (pslverr |-> pready)
    else $error("slave error without answer");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_err_on_tick: assert property ($changed(tx_phase_error) |-> s_near_tick)
    else $error("error output moved off a tick");
  a_err_char_sent: assert property (
    tx_char_valid && tx_phase_error && err_ticks >= 2'd2 |-> tx_line_char == ERR_CHAR)
    else $error("host data sent during error");
  a_mult_legal: assert property (
    tx_bit_multiplier == MULT_FULL || tx_bit_multiplier == MULT_HALF)
    else $error("illegal bit clock multiplier");
  a_line_on_tick: assert property ($changed(tx_line_char) |-> s_near_tick)
    else $error("line character moved off a tick");
  a_valid_after_tick: assert property (char_rate_clock_out |-> ##[0:1] tx_char_valid)
    else $error("tick without character strobe");
endmodule

bind tia_tx_input_align tia_tx_input_align_checker #(.DEPTH(DEPTH)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_line_char(tx_line_char),
  .tx_char_valid(tx_char_valid), .char_rate_clock_out(char_rate_clock_out),
  .tx_bit_multiplier(tx_bit_multiplier), .tx_phase_error(tx_phase_error));

// ### test/tia_host_model.sv
// ==================================================================
// host character source: clock and counting characters
// assumes the bench stops it only for whole periods
`timescale 1ns/1ps
module tia_host_model
  import tia_pkg::*;
#(
  parameter int         HALF_NS   = 1000,
  parameter int         OFFSET_NS = 500,
  parameter logic [9:0] FIRST     = 10'h100
) (
  input  wire logic                       run,              // clock runs
  output logic                            host_tx_clock,    // host clock
  output logic [tia_pkg::CHAR_W-1:0]      tx_parallel_char  // character
);
  // data moves half a period away from the capturing edge
  initial begin
    host_tx_clock = 1'b0;
    tx_parallel_char = FIRST;
    #(OFFSET_NS);
    forever begin
      if (run) begin
        host_tx_clock = 1'b1;
        #(HALF_NS);
        host_tx_clock = 1'b0;
        tx_parallel_char = tx_parallel_char + 10'h001;
        #(HALF_NS);
      end else begin
        #(2 * HALF_NS);
      end
    end
  end
endmodule

// ### test/tb.sv
// ==================================================================
// testbench for the transmit input phase-align block
// assumes the host model and the bound checker
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module tb;
  import tia_pkg::*;
  logic        mclk, rst_n, run, reference_clock_in, config_write_strobe, err;
  logic        host_tx_clock, tx_char_valid, char_rate_clock_out, tx_phase_error, irq;
  logic        psel, penable, pwrite, pready, pslverr, seq_on, have_prev;
  logic [9:0]  tx_parallel_char, tx_line_char, prev;
  logic [3:0]  config_addr;
  logic [6:0]  config_data;
  logic [7:0]  paddr;
  logic [4:0]  tx_bit_multiplier;
  logic [31:0] pwdata, prdata, rd;
  int          fail_count, checks_done;

  // ==================================================================
  // clocks and parts
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    reference_clock_in = 1'b0;
    forever #1000 reference_clock_in = ~reference_clock_in;
  end
  tia_tx_input_align DUT (.mclk(mclk), .rst_n(rst_n), .tx_parallel_char(tx_parallel_char),
    .host_tx_clock(host_tx_clock), .reference_clock_in(reference_clock_in),
    .config_write_strobe(config_write_strobe), .config_addr(config_addr),
    .config_data(config_data), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_line_char(tx_line_char), .tx_char_valid(tx_char_valid),
    .char_rate_clock_out(char_rate_clock_out), .tx_bit_multiplier(tx_bit_multiplier),
    .tx_phase_error(tx_phase_error), .irq(irq));
  tia_host_model u_host (.run(run), .host_tx_clock(host_tx_clock),
    .tx_parallel_char(tx_parallel_char));

  // successive characters on the line count up by one
  always @(posedge mclk) begin
    if (seq_on && tx_char_valid === 1'b1) begin
      if (have_prev) `CHK(tx_line_char, prev + 10'h001)
      prev = tx_line_char;
      have_prev = 1'b1;
    end
  end

  // ==================================================================
  // tasks
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      summarize();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic ticks(input int n);
    int c, k;
    c = 0; k = 0;
    while (c < n && k < 2000) begin
      @(posedge mclk);
      k++;
      if (char_rate_clock_out === 1'b1) c++;
    end
    if (c < n) begin fail_count++; summarize(); end
  endtask
  task automatic tick_gap(input int e);
    int n;
    ticks(1);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (char_rate_clock_out !== 1'b1 && n < 40);
    `CHK(n, e)
  endtask
  task automatic wait_err(input logic v);
    int k;
    k = 0;
    while (tx_phase_error !== v && k < 400) begin @(posedge mclk); k++; end
    if (tx_phase_error !== v) begin fail_count++; summarize(); end
  endtask
  task automatic cfg(input logic [6:0] d);
    @(posedge mclk);
    config_addr <= CFG_ADDR_TXCTL; config_data <= d;
    repeat (3) @(posedge mclk);
    config_write_strobe <= 1'b1;
    repeat (4) @(posedge mclk);
    config_write_strobe <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic pause(input int periods);
    @(posedge mclk);
    run <= 1'b0;
    repeat (20 * periods) @(posedge mclk);
    run <= 1'b1;
  endtask

  // ==================================================================
  // main sequence
  initial begin
    rst_n = 1'b0; run = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; config_write_strobe = 1'b0; config_addr = 4'h0; config_data = 7'h04;
    seq_on = 1'b0; have_prev = 1'b0; fail_count = 0; checks_done = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(REG_CTRL, 32'h4);
    rdchk(REG_INT_STAT, 32'h0);
    rdchk(8'h14, 32'h0);
    `CHK(err, 1'b1)
    wr(REG_INT_CLR, 32'h3);
    rdchk(REG_INT_CLR, 32'h0);
    `CHK(tx_bit_multiplier, MULT_FULL)
    wr(REG_CTRL, 32'h7);
    rdchk(REG_CTRL, 32'h7);
    `CHK(tx_bit_multiplier, MULT_HALF)
    tick_gap(10);
    wr(REG_CTRL, 32'h5);
    rdchk(REG_CTRL, 32'h5);
    `CHK(tx_bit_multiplier, MULT_FULL)
    tick_gap(20);
    ticks(3); seq_on = 1'b1; ticks(6); seq_on = 1'b0; have_prev = 1'b0;
    wr(REG_CTRL, 32'h0);
    wr(REG_CTRL, 32'h4);
    wait_err(1'b0);
    ticks(4); seq_on = 1'b1; ticks(6);
    pause(1); ticks(6);
    `CHK(tx_phase_error, 1'b0)
    seq_on = 1'b0; have_prev = 1'b0;
    wr(REG_INT_CLR, 32'h3);
    wr(REG_INT_EN, 32'h3);
    rdchk(REG_INT_STAT, 32'h0);
    pause(6); wait_err(1'b1); ticks(3);
    `CHK(tx_line_char, ERR_CHAR)
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[1:0], 2'b11)
    rdchk(REG_INT_STAT, 32'h1);
    `CHK(irq, 1'b1)
    wr(REG_INT_EN, 32'h0);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    ticks(4);
    `CHK(tx_phase_error, 1'b1)
    cfg(7'h00); cfg(7'h04); wait_err(1'b0);
    rdchk(REG_INT_STAT, 32'h3);
    rdchk(REG_CTRL, 32'h4);
    wr(REG_INT_CLR, 32'h3);
    rdchk(REG_INT_STAT, 32'h0);
    ticks(4); seq_on = 1'b1; ticks(6);
    summarize();
  end
endmodule
